//--- design/acmod_core.v
`timescale 1ns/1ps
`include "acmod_map.vh"

// Summary of operation
// - Pattern 00 1000 d fffffff copies the addressed file register to a destination.
// - Copy with d one writes back to the file; d zero loads the accumulator.
// - Copy updates the zero flag from the moved value.
// - Copy spans one instruction cycle: decode, read file, process, write destination.
// - Pattern 00 0000 1 fffffff stores the accumulator to the file, flags unchanged.
// - Store spans one cycle; the file write happens in the last phase.
// - Pattern 11 00xx with literal loads the accumulator; no flags; one cycle.

module acmod_core #(
    parameter DATA_WIDTH = 8,
    parameter ADDR_WIDTH = 7
) (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire [13:0] instr_word,
    input wire [DATA_WIDTH-1:0] file_rd_data,
    output wire [1:0] phase_q,
    output reg [ADDR_WIDTH-1:0] file_addr_q,
    output reg file_rd_q,
    output reg file_wr_q,
    output reg [DATA_WIDTH-1:0] file_wr_data_q,
    output reg [DATA_WIDTH-1:0] acc_q,
    output reg zero_flag_q,
    output reg zero_upd_q,
    output reg unknown_instr_q,
    output reg instr_done_q
);
    localparam [DATA_WIDTH-1:0] DATA_ZERO = {DATA_WIDTH{1'b0}};

    reg [13:0] iw_q;
    reg [2:0] op_q;
    reg [DATA_WIDTH-1:0] operand_q;
    reg [2:0] op_d;
    reg [DATA_WIDTH-1:0] result_d;
    wire dest_file;

    // Maps an instruction word to one of the four handled classes
    function [2:0] decode_op;
        input [13:0] iw;
        begin
            if (iw[`ACMOD_OP6_MSB:`ACMOD_OP6_LSB] == `ACMOD_PAT_COPY_FILE) begin
                decode_op = `ACMOD_OP_COPY_FILE;
            end else if (iw[`ACMOD_OP6_MSB:`ACMOD_OP7_LSB] == `ACMOD_PAT_STORE_ACC) begin
                decode_op = `ACMOD_OP_STORE_ACC;
            end else if (iw[`ACMOD_OP6_MSB:`ACMOD_OP4_LSB] == `ACMOD_PAT_LOAD_LIT) begin
                decode_op = `ACMOD_OP_LOAD_LIT;
            end else if (iw[`ACMOD_OP6_MSB:`ACMOD_OP6_LSB] == `ACMOD_PAT_OR_FILE) begin
                decode_op = `ACMOD_OP_OR_FILE;
            end else begin
                decode_op = `ACMOD_OP_NONE;
            end
        end
    endfunction

    // True when the operation reads a file register in the read phase
    function reads_file;
        input [2:0] op;
        begin
            reads_file = (op == `ACMOD_OP_COPY_FILE) || (op == `ACMOD_OP_OR_FILE);
        end
    endfunction

    // One zero test keeps copy and OR from drifting apart
    function is_zero;
        input [DATA_WIDTH-1:0] v;
        begin
            is_zero = (v == DATA_ZERO);
        end
    endfunction

    // Store always writes the file; copy and OR only when the destination bit is set
    function writes_file;
        input [2:0] op;
        input dest;
        begin
            writes_file = (op == `ACMOD_OP_STORE_ACC) || (dest && reads_file(op));
        end
    endfunction

    // Literal load always lands in the accumulator; copy and OR only with the destination bit clear
    function loads_acc;
        input [2:0] op;
        input dest;
        begin
            loads_acc = (op == `ACMOD_OP_LOAD_LIT) || (!dest && reads_file(op));
        end
    endfunction

    acmod_phase u_phase (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .phase_q(phase_q)
    );

    always @* begin
        op_d = decode_op(instr_word);
    end

    // Store carries bit 7 as part of its opcode, so it never selects a destination
    assign dest_file = iw_q[`ACMOD_DEST_BIT];

    // Decode phase: capture word and class
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            iw_q <= `ACMOD_RST_IW;
            op_q <= `ACMOD_OP_NONE;
            unknown_instr_q <= 1'b0;
        end else if (clk_en && phase_q == `ACMOD_PH_DECODE) begin
            iw_q <= instr_word;
            op_q <= op_d;
            // Unknown words run as a no-op; apart from this flag they only load file_addr_q, clear file_wr_data_q and pulse instr_done_q
            unknown_instr_q <= (op_d == `ACMOD_OP_NONE);
        end
    end

    // Read phase: address and strobe are shown during the read phase
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            file_addr_q <= `ACMOD_RST_ADDR;
            file_rd_q <= 1'b0;
        end else if (clk_en) begin
            if (phase_q == `ACMOD_PH_DECODE) begin
                file_addr_q <= instr_word[`ACMOD_ADDR_MSB:`ACMOD_ADDR_LSB];
                file_rd_q <= reads_file(op_d);
            end else begin
                file_rd_q <= 1'b0;
            end
        end
    end

    // Operand latch at the end of the read phase; literal needs no file access
    // The file must answer from file_addr_q alone: a registered read would land a phase late
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            operand_q <= DATA_ZERO;
        end else if (clk_en && phase_q == `ACMOD_PH_READ) begin
            if (op_q == `ACMOD_OP_LOAD_LIT) begin
                operand_q <= iw_q[`ACMOD_LIT_MSB:`ACMOD_LIT_LSB];
            end else if (op_q == `ACMOD_OP_STORE_ACC) begin
                operand_q <= acc_q;
            end else begin
                operand_q <= file_rd_data;
            end
        end
    end

    always @* begin
        case (op_q)
            `ACMOD_OP_OR_FILE: result_d = acc_q | operand_q;
            `ACMOD_OP_COPY_FILE: result_d = operand_q;
            `ACMOD_OP_STORE_ACC: result_d = operand_q;
            `ACMOD_OP_LOAD_LIT: result_d = operand_q;
            default: result_d = DATA_ZERO;
        endcase
    end

    // Process phase: the result and every destination write appear together in
    // the write phase, so nothing downstream sees a half-finished instruction
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            file_wr_q <= 1'b0;
            file_wr_data_q <= DATA_ZERO;
        end else if (clk_en) begin
            if (phase_q == `ACMOD_PH_PROCESS) begin
                file_wr_data_q <= result_d;
                file_wr_q <= writes_file(op_q, dest_file);
            end else begin
                file_wr_q <= 1'b0;
            end
        end
    end

    // Accumulator and zero flag take their new values entering the write phase
    // Store and literal load leave the flag alone, so a saved test result survives them
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            acc_q <= `ACMOD_RST_ACC;
            zero_flag_q <= `ACMOD_RST_ZERO;
            zero_upd_q <= 1'b0;
        end else if (clk_en) begin
            zero_upd_q <= 1'b0;
            if (phase_q == `ACMOD_PH_PROCESS) begin
                case (op_q)
                    `ACMOD_OP_LOAD_LIT: begin
                        acc_q <= result_d;
                    end
                    `ACMOD_OP_COPY_FILE: begin
                        if (loads_acc(op_q, dest_file)) begin
                            acc_q <= result_d;
                        end
                        zero_flag_q <= is_zero(result_d);
                        zero_upd_q <= 1'b1;
                    end
                    `ACMOD_OP_OR_FILE: begin
                        if (loads_acc(op_q, dest_file)) begin
                            acc_q <= result_d;
                        end
                        zero_flag_q <= is_zero(result_d);
                        zero_upd_q <= 1'b1;
                    end
                    default: begin
                        acc_q <= acc_q;
                    end
                endcase
            end
        end
    end

    // One pulse per instruction cycle, shown during the write phase
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            instr_done_q <= 1'b0;
        end else if (clk_en) begin
            instr_done_q <= (phase_q == `ACMOD_PH_PROCESS);
        end
    end
endmodule

//--- design/acmod_map.vh
`ifndef ACMOD_MAP_VH
`define ACMOD_MAP_VH

// Instruction word layout
`define ACMOD_IW_WIDTH 14
`define ACMOD_DATA_WIDTH 8
`define ACMOD_ADDR_WIDTH 7
`define ACMOD_DEST_BIT 7
`define ACMOD_ADDR_LSB 0
`define ACMOD_ADDR_MSB 6
`define ACMOD_LIT_LSB 0
`define ACMOD_LIT_MSB 7

// Opcode fields and patterns
`define ACMOD_OP6_MSB 13
`define ACMOD_OP6_LSB 8
`define ACMOD_OP7_LSB 7
`define ACMOD_OP4_LSB 10
`define ACMOD_PAT_OR_FILE 6'h04
`define ACMOD_PAT_COPY_FILE 6'h08
`define ACMOD_PAT_STORE_ACC 7'h01
`define ACMOD_PAT_LOAD_LIT 4'hC

// Decoded operation classes
`define ACMOD_OP_NONE 3'h0
`define ACMOD_OP_OR_FILE 3'h1
`define ACMOD_OP_COPY_FILE 3'h2
`define ACMOD_OP_STORE_ACC 3'h3
`define ACMOD_OP_LOAD_LIT 3'h4

// Phase codes within one instruction cycle
`define ACMOD_PH_DECODE 2'h0
`define ACMOD_PH_READ 2'h1
`define ACMOD_PH_PROCESS 2'h2
`define ACMOD_PH_WRITE 2'h3

// Reset values
`define ACMOD_RST_ACC 8'h00
`define ACMOD_RST_ZERO 1'b0
`define ACMOD_RST_ADDR 7'h00
`define ACMOD_RST_IW 14'h0000

`endif

//--- design/acmod_phase.v
`timescale 1ns/1ps
`include "acmod_map.vh"

module acmod_phase (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    output reg [1:0] phase_q
);
    // Four core clocks with clk_en high make one instruction cycle; wraps from write back to decode
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            phase_q <= `ACMOD_PH_DECODE;
        end else if (clk_en) begin
            phase_q <= phase_q + 2'h1;
        end
    end
endmodule

//--- sim/acmod_core_asserts.sv
`timescale 1ns/1ps
module acmod_core_asserts (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire [13:0] instr_word,
    input wire [7:0] file_rd_data,
    input wire [1:0] phase_q,
    input wire [6:0] file_addr_q,
    input wire file_rd_q,
    input wire file_wr_q,
    input wire [7:0] file_wr_data_q,
    input wire [7:0] acc_q,
    input wire zero_flag_q,
    input wire zero_upd_q,
    input wire unknown_instr_q,
    input wire instr_done_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_phase_step: assert property (reset_n && clk_en |=> phase_q == $past(phase_q) + 2'h1)
        else $error("phase did not step");
    chk_phase_hold: assert property (!clk_en |=> $stable(phase_q) && $stable(acc_q))
        else $error("state moved while disabled");
    chk_read_addr: assert property ((reset_n && phase_q == 2'h0 && clk_en &&
        (instr_word[13:8] == 6'h08 || instr_word[13:8] == 6'h04)) |=> file_rd_q && file_addr_q == $past(instr_word[6:0]))
        else $error("file read missing");
    chk_store_write: assert property ((reset_n && phase_q == 2'h0 && instr_word[13:7] == 7'h01)
        ##0 clk_en [*3] |=> file_wr_q && !file_rd_q && file_wr_data_q == $past(acc_q) &&
        file_addr_q == $past(instr_word[6:0], 3))
        else $error("store write wrong");
    chk_load_acc: assert property ((reset_n && phase_q == 2'h0 && clk_en && instr_word[13:10] == 4'hC)
        ##1 clk_en [*2] |=> acc_q == $past(instr_word[7:0], 3) && zero_flag_q == $past(zero_flag_q, 3))
        else $error("literal load wrong");
    chk_zero_file: assert property (zero_upd_q && file_wr_q |-> zero_flag_q == (file_wr_data_q == 8'h00))
        else $error("zero flag wrong for file");
    chk_zero_acc: assert property (zero_upd_q && !file_wr_q |-> zero_flag_q == (acc_q == 8'h00))
        else $error("zero flag wrong for acc");
    chk_flag_cause: assert property ($changed(zero_flag_q) |-> zero_upd_q)
        else $error("zero flag moved without update");
    chk_strobe_phase: assert property (file_wr_q || zero_upd_q |-> phase_q == 2'h3 && instr_done_q)
        else $error("write outside last phase");
    chk_unknown_quiet: assert property (unknown_instr_q |-> !file_rd_q && !file_wr_q && !zero_upd_q)
        else $error("unknown word had effect");
endmodule
bind acmod_core acmod_core_asserts u_chk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .instr_word(instr_word),
    .file_rd_data(file_rd_data),
    .phase_q(phase_q),
    .file_addr_q(file_addr_q),
    .file_rd_q(file_rd_q),
    .file_wr_q(file_wr_q),
    .file_wr_data_q(file_wr_data_q),
    .acc_q(acc_q),
    .zero_flag_q(zero_flag_q),
    .zero_upd_q(zero_upd_q),
    .unknown_instr_q(unknown_instr_q),
    .instr_done_q(instr_done_q)
);

//--- sim/test_accumulator_move_or_decode.sv
`timescale 1ns/1ps
module test_accumulator_move_or_decode;
    reg clk_sys, reset_n, clk_en;
    reg [13:0] instr_word, w;
    wire [7:0] file_rd_data, file_wr_data_q, acc_q;
    wire [1:0] phase_q;
    wire [6:0] file_addr_q;
    wire file_rd_q, file_wr_q, zero_flag_q, zero_upd_q, unknown_instr_q, instr_done_q;
    reg [7:0] fmem [0:127];
    reg [7:0] emem [0:127];
    reg [7:0] ea;
    reg ez;
    reg [31:0] rs, cs;
    reg [19:0] expq [$];
    integer miscompares, checks_done, i, k;
    localparam [111:0] FIXED = {14'h0000, 14'h0482, 14'h0402, 14'h0005, 14'h0085, 14'h334F, 14'h305A, 14'h0885};
    acmod_core DUT (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .instr_word(instr_word),
        .file_rd_data(file_rd_data),
        .phase_q(phase_q),
        .file_addr_q(file_addr_q),
        .file_rd_q(file_rd_q),
        .file_wr_q(file_wr_q),
        .file_wr_data_q(file_wr_data_q),
        .acc_q(acc_q),
        .zero_flag_q(zero_flag_q),
        .zero_upd_q(zero_upd_q),
        .unknown_instr_q(unknown_instr_q),
        .instr_done_q(instr_done_q)
    );
    wire [19:0] seen_res = {file_wr_q, file_wr_q ? file_wr_data_q : 8'h00, acc_q, zero_flag_q, zero_upd_q,
        unknown_instr_q};
    // Memory answers combinationally from the address, as the core expects
    assign file_rd_data = fmem[file_addr_q];
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string what, input [19:0] seen, input [19:0] expv);
        begin
            checks_done = checks_done + 1;
            if (seen !== expv) begin
                miscompares = miscompares + 1;
                $display("unexpected %s: expected %h, seen %h", what, expv, seen);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d, mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task issue(input [13:0] iw);
        reg [7:0] v;
        reg wr, upd, unk;
        begin
            wr = 0;
            upd = 0;
            unk = 0;
            v = emem[iw[6:0]];
            if (iw[13:8] == 6'h08 || iw[13:8] == 6'h04) begin
                if (iw[10]) v = v | ea;
                upd = 1;
                ez = (v == 8'h00);
                wr = iw[7];
                if (iw[7]) emem[iw[6:0]] = v;
                else ea = v;
            end else if (iw[13:7] == 7'h01) begin
                wr = 1;
                v = ea;
                emem[iw[6:0]] = ea;
            end else if (iw[13:10] == 4'hC) ea = iw[7:0];
            else unk = 1;
            expq.push_back({wr, wr ? v : 8'h00, ea, ez, upd, unk});
            instr_word <= iw;
        end
    endtask
    // Only the memory model follows the core's writes; the expectation keeps its own copy
    always @(posedge clk_sys) begin
        if (file_wr_q && clk_en) fmem[file_addr_q] <= file_wr_data_q;
        if (reset_n) begin
            cs = lfsr(cs);
            clk_en <= cs[1:0] != 2'h0;
        end
        if (reset_n && clk_en && instr_done_q) begin
            if (expq.size() == 0) check("spare result", 20'h00001, 20'h00000);
            else check("result", seen_res, expq.pop_front());
        end
    end
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        reset_n = 0;
        clk_en = 1;
        instr_word = 14'h0000;
        miscompares = 0;
        checks_done = 0;
        rs = 32'h00016E56;
        cs = 32'h0001A5C3;
        ea = 8'h00;
        ez = 0;
        for (i = 0; i < 128; i = i + 1) begin
            rs = lfsr(rs);
            fmem[i] = (i == 5 || i == 2) ? 8'h00 : rs[7:0];
            emem[i] = fmem[i];
        end
        repeat (20) @(posedge clk_sys);
        issue(FIXED[13:0]);
        reset_n <= 1;
        for (i = 1; i < 208; i = i + 1) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k = k + 1;
            end while (!(phase_q == 2'h3 && clk_en) && k < 60);
            if (k >= 60) begin
                miscompares = miscompares + 1;
                complete_run;
            end
            rs = lfsr(rs);
            w = rs[13:0];
            if (rs[17:15] < 3'h3) w = {rs[17:15] == 3'h0 ? 6'h08 : rs[17:15] == 3'h1 ? 6'h04 : 6'h00,
                rs[17:15] == 3'h2 ? 1'b1 : rs[7], 4'h0, rs[2:0]};
            else if (rs[17:15] == 3'h3) w[13:10] = 4'hC;
            issue(i < 8 ? FIXED[i*14 +: 14] : w);
        end
        k = 0;
        while (expq.size() != 0 && k < 60) begin
            @(posedge clk_sys);
            k = k + 1;
        end
        if (k >= 60) miscompares = miscompares + 1;
        complete_run;
    end
endmodule
